// ### shared/rs_enc_pkg.sv
// Shared constants and types of the Reed-Solomon block encoder.
// Assumes one 100 MHz clock domain and an AXI4-Lite register port.
`default_nettype none
package rs_enc_pkg;
  localparam int SYM_W = 12;
  localparam int MAX_CH = 128;
  localparam int CH_W = 7;
  localparam int MAX_PAR = 32;
  localparam int PAR_W = 6;
  localparam int ADDR_W = 8;
  localparam int PIPE_N = 5;
  localparam int TAP_STD = 2;
  localparam int TAP_CCSDS = 4;
  localparam int LAT_STD = 4;
  localparam int LAT_CCSDS = 6;

  typedef logic [SYM_W-1:0] sym_t;
  typedef logic [PAR_W-1:0] rcnt_t;
  typedef logic [CH_W-1:0] ch_t;
  typedef logic [12:0] poly_t;
  typedef logic [MAX_PAR-1:0][SYM_W-1:0] prow_t;
  typedef enum logic [1:0] {CFG_IDLE, CFG_BETA, CFG_ROOT, CFG_POLY} cfg_state_t;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FIELD = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_GEN = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CHAN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // Field positions.
  localparam int CTRL_APPLY = 0;
  localparam int CTRL_ND = 1;
  localparam int CTRL_VAR = 2;
  localparam int CTRL_LAT6 = 3;
  localparam int CTRL_PRESET = 4;
  localparam int HI_LO = 16;

  // Values after reset.
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_CODE = 32'h00df_00ff;
  localparam logic [31:0] RST_FIELD = 32'h0008_0000;
  localparam logic [31:0] RST_GEN = 32'h0001_0000;
  localparam logic [31:0] RST_CHAN = 32'h0000_0001;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam sym_t ALPHA = 12'h002;

  // Code presets: 0 custom, then the fixed standard codes.
  localparam logic [2:0] PRESET_CCSDS = 3'h2;
  localparam logic [3:0] PRESET_SYM_W = 4'h8;
  localparam logic [11:0] PRESET_N [8] = '{12'h000, 12'h0cf, 12'h0ff, 12'h0cc,
                                          12'h07e, 12'h0d0, 12'h0db, 12'h0e1};
  localparam logic [11:0] PRESET_K [8] = '{12'h000, 12'h0bb, 12'h0df, 12'h0bc,
                                          12'h070, 12'h0c0, 12'h0c9, 12'h0cd};
  // Default primitive field polynomial by symbol width.
  localparam poly_t DEF_POLY [16] = '{13'h0000, 13'h0000, 13'h0000, 13'h000b,
                                      13'h0013, 13'h0025, 13'h0043, 13'h0089,
                                      13'h011d, 13'h0211, 13'h0409, 13'h0805,
                                      13'h1053, 13'h0000, 13'h0000, 13'h0000};
endpackage : rs_enc_pkg
`default_nettype wire

// ### rtl/rs_block_encoder.sv
// Systematic Reed-Solomon block encoder with time-multiplexed channels.
// Assumes source and sink logic on i_clk and an AXI4-Lite master for setup.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`default_nettype none

module rs_block_encoder (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // AXI4-Lite write channels.
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [rs_enc_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read channels.
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [rs_enc_pkg::ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Symbol input.
  input wire logic i_en,
  input wire rs_enc_pkg::sym_t i_data,
  input wire logic i_start,
  input wire logic i_bypass,
  input wire logic i_new_symbol_valid,
  input wire rs_enc_pkg::sym_t i_block_len,
  input wire rs_enc_pkg::rcnt_t i_check_count,
  // Symbol output.
  output rs_enc_pkg::sym_t o_data,
  output logic o_info,
  output logic o_out_valid,
  output rs_enc_pkg::ch_t o_out_channel,
  output logic o_accept_info,
  output logic o_ready_first
);
  import rs_enc_pkg::*;

  function automatic sym_t gf_mul(input sym_t a, input sym_t b, input poly_t poly,
                                  input logic [3:0] w);
    poly_t acc;
    acc = '0;
    for (int i = SYM_W - 1; i >= 0; i--) begin
      acc = {acc[SYM_W-1:0], 1'b0};
      if (acc[w]) begin
        acc = acc ^ poly;
      end
      if (b[i]) begin
        acc = acc ^ {1'b0, a};
      end
    end
    return acc[SYM_W-1:0];
  endfunction : gf_mul

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave.
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [1:0] bresp_q, rresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] ctrl_q, code_q, field_q, gen_q, chan_q;
  cfg_state_t cfg_st_q;
  logic cfg_ok_q, cfg_err_q;
  rcnt_t act_r;

  wire aw_fire = i_awvalid & awready_q;
  wire w_fire = i_wvalid & wready_q;
  wire ar_fire = i_arvalid & arready_q;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire [ADDR_W-3:0] wa = awaddr_q[ADDR_W-1:2];
  wire [ADDR_W-3:0] ra = i_araddr[ADDR_W-1:2];
  wire wr_ctrl = wr_go && wa == OFS_CTRL[ADDR_W-1:2];
  wire wr_code = wr_go && wa == OFS_CODE[ADDR_W-1:2];
  wire wr_field = wr_go && wa == OFS_FIELD[ADDR_W-1:2];
  wire wr_gen = wr_go && wa == OFS_GEN[ADDR_W-1:2];
  wire wr_chan = wr_go && wa == OFS_CHAN[ADDR_W-1:2];
  wire wr_hit = wr_ctrl | wr_code | wr_field | wr_gen | wr_chan;
  wire [31:0] ctrl_new = merge(ctrl_q, wdata_q, wstrb_q);
  wire apply = wr_ctrl & wstrb_q[0] & wdata_q[CTRL_APPLY];
  wire busy = cfg_st_q != CFG_IDLE;
  wire [31:0] status_w = {18'h0, act_r, 5'h0, busy, cfg_err_q, cfg_ok_q};
  wire rd_hit = ra <= OFS_STATUS[ADDR_W-1:2];
  wire [31:0] rd_val = (ra == OFS_CTRL[ADDR_W-1:2]) ? ctrl_q :
                       (ra == OFS_CODE[ADDR_W-1:2]) ? code_q :
                       (ra == OFS_FIELD[ADDR_W-1:2]) ? field_q :
                       (ra == OFS_GEN[ADDR_W-1:2]) ? gen_q :
                       (ra == OFS_CHAN[ADDR_W-1:2]) ? chan_q :
                       (ra == OFS_STATUS[ADDR_W-1:2]) ? status_w : 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (aw_fire) begin
      awaddr_q <= i_awaddr;
    end
    if (w_fire) begin
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // The apply bit is self-clearing; the other bits are stored.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= RST_CTRL;
      code_q <= RST_CODE;
      field_q <= RST_FIELD;
      gen_q <= RST_GEN;
      chan_q <= RST_CHAN;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_new & ~32'h0000_0001;
      if (wr_code) code_q <= merge(code_q, wdata_q, wstrb_q);
      if (wr_field) field_q <= merge(field_q, wdata_q, wstrb_q);
      if (wr_gen) gen_q <= merge(gen_q, wdata_q, wstrb_q);
      if (wr_chan) chan_q <= merge(chan_q, wdata_q, wstrb_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code resolution and checking at apply time.
  wire [2:0] preset = ctrl_new[CTRL_PRESET +: 3];
  wire is_preset = preset != 3'h0;
  wire [11:0] res_n = is_preset ? PRESET_N[preset] : code_q[11:0];
  wire [11:0] res_k = is_preset ? PRESET_K[preset] : code_q[HI_LO +: 12];
  wire [3:0] res_w = is_preset ? PRESET_SYM_W : field_q[HI_LO +: 4];
  wire poly_t res_poly = (is_preset || field_q[12:0] == 13'h0) ? DEF_POLY[res_w] :
                         field_q[12:0];
  wire sym_t res_fmax = sym_t'((13'h1 << res_w) - 13'h1);
  wire [11:0] res_r = res_n - res_k;
  wire sym_t res_h = gen_q[HI_LO +: 12];
  wire [7:0] res_nch = chan_q[7:0];
  wire ok_w = res_w >= 4'h3 && res_w <= 4'hc && (res_poly >> res_w) == 13'h1;
  wire ok_n = res_n >= 12'h3 && res_n <= res_fmax;
  wire ok_k = res_k >= 12'h1 && res_k <= res_n - 12'h2 && res_r <= 12'(MAX_PAR);
  wire ok_h = res_h >= 12'h1 && res_h <= res_fmax;
  wire ok_c = res_nch >= 8'h1 && res_nch <= 8'(MAX_CH);
  wire res_ok = ok_w & ok_n & ok_k & ok_h & ok_c;
  wire cfg_load = ~busy & apply & res_ok;

  logic [3:0] act_w;
  poly_t act_poly;
  logic [11:0] act_n;
  sym_t act_r0, act_h, act_fmax;
  logic act_nd, act_var, act_lat6;
  logic [7:0] act_nch;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_w <= 4'h0;
      act_poly <= 13'h0;
      act_n <= 12'h0;
      act_r <= '0;
      act_r0 <= '0;
      act_h <= '0;
      act_fmax <= '0;
      act_nd <= 1'b0;
      act_var <= 1'b0;
      act_lat6 <= 1'b0;
      act_nch <= 8'h1;
    end else if (cfg_load) begin
      act_w <= res_w;
      act_poly <= res_poly;
      act_n <= res_n;
      act_r <= rcnt_t'(res_r);
      act_r0 <= gen_q[11:0];
      act_h <= res_h;
      act_fmax <= res_fmax;
      act_nd <= ctrl_new[CTRL_ND];
      act_var <= ctrl_new[CTRL_VAR];
      act_lat6 <= ctrl_new[CTRL_LAT6] | (preset == PRESET_CCSDS);
      act_nch <= res_nch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator build: beta = alpha^h, root = beta^r0, then one factor per step.
  logic [11:0] step_q;
  sym_t beta_q, root_q;
  logic [MAX_PAR:0][SYM_W-1:0] g_q, g_new;
  prow_t gtab_q [MAX_PAR+1];

  for (genvar gi = 0; gi <= MAX_PAR; gi++) begin : g_step
    if (gi == 0) begin : g_low
      assign g_new[gi] = gf_mul(g_q[gi], root_q, act_poly, act_w);
    end else begin : g_high
      assign g_new[gi] = g_q[gi-1] ^ gf_mul(g_q[gi], root_q, act_poly, act_w);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_st_q <= CFG_IDLE;
      cfg_ok_q <= 1'b0;
      cfg_err_q <= 1'b0;
      step_q <= 12'h0;
      beta_q <= '0;
      root_q <= '0;
    end else begin
      case (cfg_st_q)
        CFG_IDLE: begin
          if (apply) begin
            cfg_ok_q <= 1'b0;
            cfg_err_q <= ~res_ok;
            step_q <= 12'h0;
            beta_q <= 12'h001;
            if (res_ok) cfg_st_q <= CFG_BETA;
          end
        end
        CFG_BETA: begin
          step_q <= (step_q == act_h) ? 12'h0 : step_q + 12'h1;
          beta_q <= (step_q == act_h) ? beta_q : gf_mul(beta_q, ALPHA, act_poly, act_w);
          root_q <= 12'h001;
          if (step_q == act_h) cfg_st_q <= CFG_ROOT;
        end
        CFG_ROOT: begin
          step_q <= (step_q == act_r0) ? 12'h0 : step_q + 12'h1;
          if (step_q != act_r0) root_q <= gf_mul(root_q, beta_q, act_poly, act_w);
          if (step_q == act_r0) cfg_st_q <= CFG_POLY;
        end
        CFG_POLY: begin
          step_q <= step_q + 12'h1;
          root_q <= gf_mul(root_q, beta_q, act_poly, act_w);
          if (step_q == {6'h0, act_r} - 12'h1) begin
            cfg_st_q <= CFG_IDLE;
            cfg_ok_q <= 1'b1;
          end
        end
        default: cfg_st_q <= CFG_IDLE;
      endcase
    end
  end

  // Row d of the table holds the generator built from the first d roots.
  always_ff @(posedge i_clk) begin
    if (cfg_st_q == CFG_ROOT) begin
      g_q <= {{MAX_PAR{12'h000}}, 12'h001};
    end else if (cfg_st_q == CFG_POLY) begin
      g_q <= g_new;
      gtab_q[step_q[PAR_W-1:0] + 6'h1] <= g_new[MAX_PAR-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel encoder, one channel slot per clock with i_en high.
  logic [MAX_CH-1:0] run_q;
  logic [11:0] cnt_q [MAX_CH];
  logic [11:0] nb_q [MAX_CH];
  rcnt_t rb_q [MAX_CH];
  prow_t par_q [MAX_CH];
  ch_t ch_q;

  wire ch_t last_ch = ch_t'(act_nch - 8'h1);
  wire ch_t nxt_ch = (ch_q == last_ch) ? '0 : ch_q + 7'h1;
  wire do_start = i_start & ~i_bypass & cfg_ok_q;
  wire rcnt_t samp_r = (act_var && i_check_count != '0 && i_check_count <= act_r) ?
                       i_check_count : act_r;
  wire [11:0] samp_n = (act_var && i_block_len > {6'h0, samp_r} && i_block_len <= act_n) ?
                       i_block_len : act_n;
  wire eff_run = do_start | run_q[ch_q];
  wire [11:0] eff_cnt = do_start ? 12'h0 : cnt_q[ch_q];
  wire [11:0] eff_nb = do_start ? samp_n : nb_q[ch_q];
  wire rcnt_t eff_rb = do_start ? samp_r : rb_q[ch_q];
  wire prow_t eff_par = do_start ? '0 : par_q[ch_q];
  wire in_info = eff_cnt < eff_nb - {6'h0, eff_rb};
  wire last = eff_cnt == eff_nb - 12'h1;
  wire sym_t top = eff_par[eff_rb[4:0] - 5'h1];
  wire sym_t fb = (i_data & act_fmax) ^ top;
  wire prow_t gsel = gtab_q[eff_rb];
  wire take = cfg_ok_q & eff_run & ~i_bypass &
              (~in_info | ~act_nd | i_new_symbol_valid);
  wire wb = i_en & cfg_ok_q & ~i_bypass & (do_start | take);
  prow_t par_nxt;

  for (genvar pi = 0; pi < MAX_PAR; pi++) begin : lfsr
    wire sym_t prod = in_info ? gf_mul(fb, gsel[pi], act_poly, act_w) : '0;
    if (pi == 0) begin : lfsr_low
      assign par_nxt[pi] = prod;
    end else begin : lfsr_high
      assign par_nxt[pi] = eff_par[pi-1] ^ prod;
    end
  end

  wire nxt_run = take ? ~last : 1'b1;
  wire [11:0] nxt_cnt = take ? (last ? 12'h0 : eff_cnt + 12'h1) : eff_cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst || cfg_load) begin
      run_q <= '0;
      ch_q <= '0;
    end else if (i_en) begin
      ch_q <= nxt_ch;
      if (wb) run_q[ch_q] <= nxt_run;
    end
  end

  always_ff @(posedge i_clk) begin
    if (wb) begin
      cnt_q[ch_q] <= nxt_cnt;
      nb_q[ch_q] <= eff_nb;
      rb_q[ch_q] <= eff_rb;
      par_q[ch_q] <= take ? par_nxt : eff_par;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output delay line; bypassed and encoded symbols share it to keep order.
  wire s_valid = i_bypass | take;
  wire sym_t s_data = !s_valid ? '0 : (i_bypass || in_info) ? i_data : top;
  wire s_info = take & in_info;
  sym_t pd_q [PIPE_N];
  logic [PIPE_N-1:0] pv_q, pi_q;
  ch_t pc_q [PIPE_N];
  wire [2:0] tap = act_lat6 ? 3'(TAP_CCSDS) : 3'(TAP_STD);

  // Status of the channel that owns the next input slot.
  wire same = nxt_ch == ch_q;
  wire n_run = same ? (wb ? nxt_run : run_q[ch_q]) : run_q[nxt_ch];
  wire [11:0] n_cnt = same ? (wb ? nxt_cnt : cnt_q[ch_q]) : cnt_q[nxt_ch];
  wire [11:0] n_nb = same ? eff_nb : nb_q[nxt_ch];
  wire rcnt_t n_rb = same ? eff_rb : rb_q[nxt_ch];
  wire acc_d = cfg_ok_q & (~n_run | n_cnt < n_nb - {6'h0, n_rb});
  wire rff_d = cfg_ok_q & ~n_run;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pv_q <= '0;
      pi_q <= '0;
      o_out_valid <= 1'b0;
      o_info <= 1'b0;
      o_data <= '0;
      o_out_channel <= '0;
      o_accept_info <= 1'b0;
      o_ready_first <= 1'b0;
    end else if (i_en) begin
      pv_q <= {pv_q[PIPE_N-2:0], s_valid};
      pi_q <= {pi_q[PIPE_N-2:0], s_info};
      o_out_valid <= pv_q[tap];
      o_info <= pi_q[tap];
      o_data <= pd_q[tap];
      o_out_channel <= pc_q[tap];
      o_accept_info <= acc_d;
      o_ready_first <= rff_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pd_q <= '{default: '0};
      pc_q <= '{default: '0};
    end else if (i_en) begin
      pd_q[0] <= s_data;
      pc_q[0] <= ch_q;
      for (int s = 1; s < PIPE_N; s++) begin
        pd_q[s] <= pd_q[s-1];
        pc_q[s] <= pc_q[s-1];
      end
    end
  end

  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
endmodule : rs_block_encoder
`default_nettype wire

// ### bench/rs_enc_chk.sv
// Port checker of the Reed-Solomon block encoder.
// Assumes the four-cycle latency setting and binding by port names.
`default_nettype none
module rs_enc_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [31:0] o_rdata,
  input wire logic i_en,
  input wire rs_enc_pkg::sym_t i_data,
  input wire logic i_start,
  input wire logic i_bypass,
  input wire rs_enc_pkg::sym_t o_data,
  input wire logic o_info,
  input wire logic o_out_valid,
  input wire logic o_accept_info,
  input wire logic o_ready_first
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  bypass_fwd_a: assert property (
    i_bypass && i_en ##1 i_en[*3] |=>
    o_out_valid && !o_info && o_data == $past(i_data, 4)) else $error("bypass path wrong");
  idle_drop_a: assert property (
    o_ready_first && i_en && !(i_start && !i_bypass) ##1 i_en[*3] |=>
    !o_info && o_out_valid == $past(i_bypass, 4)) else $error("idle slot produced data");
  hold_en_a: assert property (
    !i_en |=> $stable(o_data) && $stable(o_out_valid) && $stable(o_info))
    else $error("outputs moved while disabled");
  info_valid_a: assert property (o_info |-> o_out_valid)
    else $error("info flag on invalid symbol");
  first_accept_a: assert property (o_ready_first |-> o_accept_info)
    else $error("idle channel not accepting");
  parity_no_info_a: assert property (
    !o_accept_info && i_en && !i_bypass ##1 i_en[*3] |=> !o_info)
    else $error("info flag in parity phase");
  wr_answer_a: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |=> !o_awready && !o_wready ##1 o_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read response late");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
endmodule : rs_enc_chk
bind rs_block_encoder rs_enc_chk chk_u (.*);
`default_nettype wire

// ### bench/rs_stream_peer.sv
// Symbol source and output collector facing the encoder stream ports.
// Assumes its tasks are called right after a rising clock edge.
`default_nettype none
module rs_stream_peer (
  // Clock and slot enable.
  input wire logic i_clk,
  input wire logic i_en,
  // Encoder output side.
  input wire rs_enc_pkg::sym_t i_dout,
  input wire logic i_info,
  input wire logic i_valid,
  // Encoder input side.
  output rs_enc_pkg::sym_t o_data,
  output logic o_start,
  output logic o_bypass,
  output logic o_nsv
);
  timeunit 1ns;
  timeprecision 1ps;
  import rs_enc_pkg::*;
  sym_t got_d[$];
  logic got_i[$];
  initial begin
    o_data = '0;
    o_start = 1'b0;
    o_bypass = 1'b0;
    o_nsv = 1'b0;
  end
  task automatic slot(input sym_t d, input logic st, input logic byp);
    o_data <= d;
    o_start <= st;
    o_bypass <= byp;
    o_nsv <= 1'b1;
    @(posedge i_clk);
  endtask : slot
  // Filler symbols change every slot so stale data cannot pass for parity.
  task automatic filler(input int n);
    for (int j = 0; j < n; j++) begin
      o_data <= ~o_data;
      o_start <= 1'b0;
      o_bypass <= 1'b0;
      o_nsv <= 1'b0;
      @(posedge i_clk);
    end
  endtask : filler
  always @(posedge i_clk) begin
    if (i_en && i_valid) begin
      got_d.push_back(i_dout);
      got_i.push_back(i_info);
    end
  end
endmodule : rs_stream_peer
`default_nettype wire

// ### bench/rs_block_encoder_tb_top.sv
// Self-checking bench of the Reed-Solomon block encoder.
// Assumes the checker binds itself and the peer model drives the stream.
`default_nettype none
module rs_block_encoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rs_enc_pkg::*;
  logic i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_en;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_info, o_out_valid;
  logic o_accept_info, o_ready_first, i_start, i_bypass, i_new_symbol_valid;
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp;
  sym_t i_data, i_block_len, o_data;
  rcnt_t i_check_count;
  ch_t o_out_channel;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  rs_block_encoder dut_u (.*);
  rs_stream_peer peer_u (.i_clk(i_clk), .i_en(i_en), .i_dout(o_data), .i_info(o_info),
    .i_valid(o_out_valid), .o_data(i_data), .o_start(i_start), .o_bypass(i_bypass),
    .o_nsv(i_new_symbol_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    r = o_bresp;
  endtask : wr
  // Ready is raised a cycle late so the response must stand meanwhile.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do @(posedge i_clk); while (!o_arready);
    i_arvalid <= 1'b0;
    @(posedge i_clk);
    i_rready <= 1'b1;
    do @(posedge i_clk); while (!o_rvalid);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask : rd
  task automatic apply(input logic [31:0] ctrl);
    logic [31:0] s;
    logic [1:0] r;
    wr(OFS_CTRL, ctrl, r);
    do rd(OFS_STATUS, s, r); while (s[2] || !s[0]);
  endtask : apply
  // Multiply by the primitive element in the 3-bit default field.
  function automatic logic [2:0] xt(input logic [2:0] v);
    return {v[1:0], 1'b0} ^ (v[2] ? 3'h3 : 3'h0);
  endfunction : xt
  // The code word must vanish at the first two generator roots.
  task automatic code_chk(input sym_t inf[$], input int nn);
    logic [2:0] ev0 = 3'h0;
    logic [2:0] ev1 = 3'h0;
    chk(peer_u.got_d.size(), nn);
    chk(o_out_channel, 7'h0);
    foreach (peer_u.got_d[j]) begin
      chk(peer_u.got_i[j], j < inf.size());
      if (j < inf.size()) chk(peer_u.got_d[j], inf[j]);
      ev0 ^= peer_u.got_d[j][2:0];
      ev1 = xt(ev1) ^ peer_u.got_d[j][2:0];
    end
    chk(ev0, 3'h0);
    chk(ev1, 3'h0);
    peer_u.got_d.delete();
    peer_u.got_i.delete();
  endtask : code_chk
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(OFS_CODE, d, r);
    chk(d, RST_CODE);
    rd(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(OFS_STATUS, 32'h0, r);
    chk(r, RESP_SLVERR);
    wr(OFS_CODE, 32'h0005_0007, r);
    wr(OFS_FIELD, 32'h0003_0000, r);
    chk(r, RESP_OKAY);
    apply(32'h1);
  endtask : t_regs
  task automatic t_block;
    sym_t inf[$] = '{12'h3, 12'h5, 12'h7, 12'h1, 12'h2};
    peer_u.slot(12'h4, 1'b0, 1'b0);
    peer_u.slot(12'h6, 1'b1, 1'b0);
    peer_u.slot(inf[0], 1'b1, 1'b0);
    peer_u.slot(inf[1], 1'b0, 1'b0);
    peer_u.slot(12'h6, 1'b1, 1'b1);
    for (int j = 2; j < 5; j++) peer_u.slot(inf[j], 1'b0, 1'b0);
    peer_u.filler(10);
    // The symbol of the overridden start is still emitted as information.
    chk({peer_u.got_d[0], peer_u.got_i[0]}, {12'h6, 1'b1});
    chk({peer_u.got_d[3], peer_u.got_i[3]}, {12'h6, 1'b0});
    peer_u.got_d.delete(3);
    peer_u.got_i.delete(3);
    peer_u.got_d.delete(0);
    peer_u.got_i.delete(0);
    code_chk(inf, 7);
  endtask : t_block
  task automatic t_var;
    sym_t inf[$] = '{12'h2, 12'h4, 12'h7};
    apply(32'h7);
    i_block_len <= 12'h5;
    i_check_count <= 6'h2;
    peer_u.slot(inf[0], 1'b1, 1'b0);
    i_block_len <= 12'h7;
    i_en <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_en <= 1'b1;
    peer_u.slot(inf[1], 1'b0, 1'b0);
    peer_u.filler(1);
    peer_u.slot(inf[2], 1'b0, 1'b0);
    peer_u.filler(10);
    code_chk(inf, 5);
  endtask : t_var
  task automatic t_preset;
    int rr[7] = '{20, 32, 16, 14, 16, 18, 20};
    logic [31:0] s;
    logic [1:0] r;
    for (int p = 1; p < 8; p++) begin
      apply({25'h0, p[2:0], 4'h1});
      rd(OFS_STATUS, s, r);
      chk(s[13:8], rr[p-1]);
    end
  endtask : t_preset
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    i_rst = 1'b1;
    i_en = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_awaddr = '0;
    i_araddr = '0;
    i_wdata = '0;
    i_wstrb = 4'hf;
    i_block_len = 12'h7;
    i_check_count = 6'h2;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_block();
    t_var();
    t_preset();
    wrap_up();
  end
endmodule : rs_block_encoder_tb_top
`default_nettype wire
